// file: include/srx_pkg.sv
// Constants, register map and state types of the system reset and exception controller.
// Assumes a single 25 MHz clock and a slower oscillator reference sampled as a pin.
package srx_pkg;
  // Clock rate of the controller logic.
  localparam int CLK_HZ = 25000000;
  // Width of the prescale counter and of the sequence counter.
  localparam int CNT_W = 13;
  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_BREAK = 8'h00;
  localparam logic [7:0] OFS_CAUSE = 8'h04;
  // Break status field.
  localparam int BRK_EXIT_BIT = 1;
  // Reset cause fields.
  localparam int CS_POR      = 7;
  localparam int CS_PIN      = 6;
  localparam int CS_WDOG     = 5;
  localparam int CS_BADOP    = 4;
  localparam int CS_BADFETCH = 3;
  localparam int CS_BLANK    = 2;
  localparam int CS_LOWSUP   = 1;
  // Reset values.
  localparam logic [7:0] CAUSE_POR_ONLY = 8'h80;
  localparam logic [7:0] BREAK_RST      = 8'h00;
  // Sequence lengths in reference-clock cycles.
  localparam logic [CNT_W-1:0] LONG_DRIVE   = 13'h1000;
  localparam logic [CNT_W-1:0] SHORT_DRIVE  = 13'h0020;
  localparam logic [CNT_W-1:0] RELEASE_WAIT = 13'h0040;
  localparam logic [CNT_W-1:0] STOP_RECOVER = 13'h1000;
  // Low-supply filter length in CPU cycles.
  localparam logic [3:0] LOWSUP_CYC = 4'h9;
  // Reference cycles per CPU bus cycle.
  localparam int BUS_DIV_DEF = 4;
  // Content of an erased vector byte.
  localparam logic [7:0] BLANK_BYTE = 8'hff;
  // Reset and power sequencer states.
  typedef enum logic [2:0] {SEQ_RUN, SEQ_DRIVE, SEQ_HOLD, SEQ_PIN, SEQ_STOP, SEQ_RECOV} srx_seq_t;
endpackage : srx_pkg

// file: include/srx_cnt_if.sv
// Link between the sequencer and the prescale counter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface srx_cnt_if;
  logic       tick;
  logic       clr;
  logic [12:0] cnt;
  logic       ovf;
  modport ctl (output tick, output clr, input cnt, input ovf);
  modport pre (input tick, input clr, output cnt, output ovf);
endinterface : srx_cnt_if

// file: rtl/srx_prescaler.sv
// Free-running 13-bit prescale counter with overflow pulse.
// Assumes tick is a one-cycle pulse marking a falling reference edge.
`timescale 1ns/1ns
module srx_prescaler
  import srx_pkg::*;
(
  input logic clk,
  input logic rstn,
  srx_cnt_if.pre cb
);
  logic [CNT_W-1:0] cnt_ff;
  logic             ovf_ff;
  wire              wrap = &cnt_ff;

  // Counts reference edges; only reset or an explicit clear stops it.
  always_ff @(posedge clk) begin
    if (!rstn || cb.clr) begin
      cnt_ff <= '0;
      ovf_ff <= 1'b0;
    end else begin
      ovf_ff <= cb.tick & wrap; // RL8
      if (cb.tick) begin
        cnt_ff <= cnt_ff + 13'h0001; // RL7
      end
    end
  end

  assign cb.cnt = cnt_ff;
  assign cb.ovf = ovf_ff;
endmodule : srx_prescaler

// file: rtl/srx_lowsup_filter.sv
// Low-supply detector filter: output rises after a held low-supply level.
// Assumes lowSupRaw is an asynchronous pin, high while supply is at or below trip.
`timescale 1ns/1ns
module srx_lowsup_filter
  import srx_pkg::*;
(
  input  logic clk,
  input  logic rstn,
  input  logic cpuTick,
  input  logic lowSupRaw,
  output logic lowSupDet
);
  logic       s1_ff;
  logic       s2_ff;
  logic [3:0] run_ff;

  // Two-stage synchroniser, then a saturating run counter of CPU cycles.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1_ff  <= 1'b0;
      s2_ff  <= 1'b0;
      run_ff <= 4'h0;
    end else begin
      s1_ff <= lowSupRaw;
      s2_ff <= s1_ff;
      if (!s2_ff) begin
        run_ff <= 4'h0;
      end else if (cpuTick && run_ff != LOWSUP_CYC) begin
        run_ff <= run_ff + 4'h1;
      end
    end
  end

  assign lowSupDet = (run_ff == LOWSUP_CYC); // RL4
endmodule : srx_lowsup_filter

// file: rtl/srx_system_ctrl.sv
// Reset, prescaler, interrupt latch and low-power controller with Wishbone registers.
// Assumes a CPU core on the same clock and an external open-drain reset pin.
//
// Overview of operation
// RL1 - An opcode fetch outside flash or RAM raises reset and sets bad-fetch flag.
// RL2 - Data reads from unmapped addresses cause no reset and no flag change.
// RL3 - Erased reset vector bytes cause reset, then monitor mode after release.
// RL4 - Low-supply output rises after nine consecutive CPU cycles below trip.
// RL5 - Low-supply reset sets its flag, drives pin 4096 cycles, releases 64 later.
// RL6 - Every internal reset actively drives the external reset pin low.
// RL7 - Prescale counter is 13 bits and counts falling reference edges.
// RL8 - Prescaler overflow clocks the watchdog counter.
// RL9 - External pin reset leaves the prescaler untouched; it runs after resets.
// RL10 - Pending interrupts are latched and arbitrated into a vector constant.
// RL11 - A latched interrupt stays until serviced or the mask bit clears.
// RL12 - Interrupts are checked at instruction end, only if unmasked and enabled.
// RL13 - With several pending, the highest priority one is serviced first.
// RL14 - Interrupt pending at return-from-interrupt is taken before the next instruction.
// RL15 - Software trap interrupts regardless of the mask bit.
// RL16 - All resets share one top priority and are never arbitrated; pin reset is taken only in run or stop, and internal resets override it.
// RL17 - Wait clears the mask bit and stops CPU clocks, peripherals keep running.
// RL18 - Enabled interrupt wakes from wait; stacking starts one cycle later.
// RL19 - With watchdog disable bit zero, watchdog runs also in wait mode.
// RL20 - Stop resets prescaler, gates clock outputs, recovers after 4096 cycles.
// RL21 - Break-exit-wait flag sets on break leaving wait; cleared by zero or reset.
// RL22 - Reset cause register flags last reset, clears on read; power-up sets only its bit.
// RL23 - Cause register also flags bad opcode, bad fetch, blank vector and low supply.
//
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
module srx_system_ctrl
  import srx_pkg::*;
#(
  parameter int IRQ_N   = 8,
  parameter int BUS_DIV = BUS_DIV_DEF
)(
  input  logic                       clk,
  input  logic                       rstn,
  input  logic                       wbCyc,
  input  logic                       wbStb,
  input  logic                       wbWe,
  input  logic [7:0]                 wbAdr,
  input  logic [31:0]                wbDatW,
  input  logic [3:0]                 wbSel,
  output logic [31:0]                wbDatR,
  output logic                       wbAck,
  input  logic                       refClk,
  input  logic                       lowSupplyRaw,
  input  logic                       rstPinIn,
  output logic                       rstPinOut,
  output logic                       rstPinOe,
  input  logic                       powerUpPulse,
  input  logic                       wdogTimeout,
  input  logic                       badOpcode,
  input  logic                       fetchValid,
  input  logic                       fetchOpcode,
  input  logic                       addrMapped,
  input  logic                       vectorFetch,
  input  logic [7:0]                 vectorData,
  input  logic                       instrDone,
  input  logic                       rtiDone,
  input  logic                       swiExec,
  input  logic                       waitExec,
  input  logic                       stopExec,
  input  logic                       breakIrq,
  input  logic                       iMask,
  input  logic                       intAck,
  input  logic [IRQ_N-1:0]           irqReq,
  input  logic [IRQ_N-1:0]           irqEn,
  input  logic                       wdogDisable,
  output logic                       cpuReset,
  output logic                       cpuClkEn,
  output logic                       periphClkEn,
  output logic                       clockgenEn,
  output logic                       wdogClk,
  output logic                       wdogRun,
  output logic                       clrIMask,
  output logic                       stackStart,
  output logic                       intReq,
  output logic [$clog2(IRQ_N+1)-1:0] intVector,
  output logic                       monitorMode
);
  localparam int VW = $clog2(IRQ_N + 1);
  localparam logic [VW-1:0] SWI_CODE = VW'(IRQ_N);

  // Refuses parameter values that the vector and divider widths cannot serve.
  if (IRQ_N < 1 || IRQ_N > 64 || BUS_DIV < 1 || BUS_DIV > 16) begin : g_bad_param
    $error("srx_system_ctrl: unsupported parameter value");
  end

  srx_cnt_if cb ();
  srx_prescaler u_pre (.clk(clk), .rstn(rstn), .cb(cb));

  // Reference clock and reset pin synchronisers.
  logic refS1_ff, refS2_ff, refS3_ff, pinS1_ff, pinS2_ff;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      {refS1_ff, refS2_ff, refS3_ff} <= 3'h0;
      {pinS1_ff, pinS2_ff} <= 2'h3;
    end else begin
      refS1_ff <= refClk;
      refS2_ff <= refS1_ff;
      refS3_ff <= refS2_ff;
      pinS1_ff <= rstPinIn;
      pinS2_ff <= pinS1_ff;
    end
  end

  // Falling reference edge gives the count enable.
  wire refTick = refS3_ff & ~refS2_ff; // RL7

  // CPU cycle enable from the reference edges.
  logic [3:0] busDiv_ff;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      busDiv_ff <= 4'h0;
    end else if (refTick) begin
      busDiv_ff <= (busDiv_ff == 4'(BUS_DIV - 1)) ? 4'h0 : busDiv_ff + 4'h1;
    end
  end
  wire cpuTick = refTick && busDiv_ff == 4'h0;

  logic lowSupDet;
  srx_lowsup_filter u_lvf (
    .clk      (clk),
    .rstn     (rstn),
    .cpuTick  (cpuTick),
    .lowSupRaw(lowSupplyRaw),
    .lowSupDet(lowSupDet)
  );

  // Internal reset sources; all share one request with no arbitration among them.
  srx_seq_t         seq_ff, nxt_seq;
  logic [CNT_W-1:0] seqCnt_ff, nxt_seqCnt;
  logic             longSeq_ff, nxt_longSeq;
  wire  badFetch = fetchValid & fetchOpcode & ~addrMapped; // RL1 RL2
  wire  blankVec = vectorFetch && vectorData == BLANK_BYTE; // RL3
  wire  longReq  = powerUpPulse | lowSupDet; // RL5
  wire  intRst   = longReq | badFetch | blankVec | badOpcode | wdogTimeout; // RL16
  wire  running  = seq_ff == SEQ_RUN;
  wire  pinLow   = running && !pinS2_ff;
  wire  [CNT_W-1:0] driveLim = longSeq_ff ? LONG_DRIVE : SHORT_DRIVE;
  logic waitMode_ff;
  wire  [IRQ_N-1:0] pend = irqReq & irqEn;
  wire  anyPend = |pend;
  wire  stopWake = anyPend | breakIrq;

  // Sequencer: reset drive, reset hold, pin reset, stop and stop recovery.
  always_comb begin
    nxt_seq     = seq_ff;
    nxt_seqCnt  = seqCnt_ff;
    nxt_longSeq = longSeq_ff;
    if (intRst) begin
      nxt_seq     = SEQ_DRIVE;
      nxt_seqCnt  = '0;
      nxt_longSeq = longReq;
    end else begin
      unique case (seq_ff)
        SEQ_RUN: begin
          if (pinLow) begin
            nxt_seq = SEQ_PIN;
          end else if (stopExec && !waitMode_ff) begin
            nxt_seq = SEQ_STOP;
          end
        end
        SEQ_DRIVE, SEQ_HOLD, SEQ_RECOV: begin
          if (refTick) begin
            nxt_seqCnt = seqCnt_ff + 13'h0001;
            if (seq_ff == SEQ_DRIVE && seqCnt_ff == driveLim - 13'h0001) begin
              nxt_seq    = SEQ_HOLD;
              nxt_seqCnt = '0;
            end else if (seq_ff == SEQ_HOLD && seqCnt_ff == RELEASE_WAIT - 13'h0001) begin
              nxt_seq = SEQ_RUN; // RL5
            end else if (seq_ff == SEQ_RECOV && seqCnt_ff == STOP_RECOVER - 13'h0001) begin
              nxt_seq = SEQ_RUN; // RL20
            end
          end
        end
        SEQ_PIN: begin
          if (pinS2_ff) begin
            nxt_seq    = SEQ_HOLD;
            nxt_seqCnt = '0;
          end
        end
        SEQ_STOP: begin
          if (!pinS2_ff) begin
            nxt_seq = SEQ_PIN;
          end else if (stopWake) begin
            nxt_seq    = SEQ_RECOV; // RL20
            nxt_seqCnt = '0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      seq_ff     <= SEQ_DRIVE;
      seqCnt_ff  <= '0;
      longSeq_ff <= 1'b1;
    end else begin
      seq_ff     <= nxt_seq;
      seqCnt_ff  <= nxt_seqCnt;
      longSeq_ff <= nxt_longSeq;
    end
  end

  // Pin is open drain: only ever pulled low, during internal reset drive.
  assign rstPinOut = 1'b0;
  assign rstPinOe  = seq_ff == SEQ_DRIVE; // RL6
  assign cpuReset  = seq_ff == SEQ_DRIVE || seq_ff == SEQ_HOLD || seq_ff == SEQ_PIN;
  // Prescaler clears on internal reset and in stop, never on pin reset.
  assign cb.tick   = refTick;
  assign cb.clr    = seq_ff == SEQ_DRIVE || seq_ff == SEQ_STOP; // RL9 RL20
  assign wdogClk   = cb.ovf; // RL8
  assign wdogRun   = ~wdogDisable; // RL19
  assign clockgenEn  = seq_ff != SEQ_STOP; // RL20
  assign periphClkEn = running;
  assign cpuClkEn    = running && !waitMode_ff; // RL17

  // Wait mode entry and exit with the stacking strobe one cycle after wake.
  logic clrIMask_ff, stackStart_ff;
  wire  waitWake = waitMode_ff && (anyPend || breakIrq);
  wire  recovEnd = seq_ff == SEQ_RECOV && nxt_seq == SEQ_RUN;
  always_ff @(posedge clk) begin
    if (!rstn || !running) begin
      waitMode_ff   <= 1'b0;
      clrIMask_ff   <= 1'b0;
      stackStart_ff <= recovEnd && rstn;
    end else begin
      clrIMask_ff   <= waitExec; // RL17
      stackStart_ff <= waitWake; // RL18
      if (waitExec) begin
        waitMode_ff <= 1'b1;
      end else if (waitWake) begin
        waitMode_ff <= 1'b0;
      end
    end
  end
  assign clrIMask   = clrIMask_ff;
  assign stackStart = stackStart_ff;

  // Priority encoder: lowest index is the highest priority.
  logic [VW-1:0] winner;
  always_comb begin
    winner = '0;
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (pend[i]) begin
        winner = VW'(i); // RL13
      end
    end
  end

  // Interrupt latch; an instruction end or interrupt return is a boundary.
  logic          latched_ff, iMaskPrev_ff;
  logic [VW-1:0] vec_ff;
  wire boundary = (instrDone | rtiDone) & running; // RL14
  wire hwTake   = (boundary & ~iMask | waitWake & ~breakIrq) & anyPend; // RL12
  wire iMaskFell = iMaskPrev_ff & ~iMask;
  always_ff @(posedge clk) begin
    if (!rstn || !running) begin
      latched_ff   <= 1'b0;
      vec_ff       <= '0;
      iMaskPrev_ff <= 1'b1;
    end else begin
      iMaskPrev_ff <= iMask;
      if (latched_ff) begin
        if (intAck || iMaskFell) begin
          latched_ff <= 1'b0; // RL11
        end
      end else if (swiExec) begin
        latched_ff <= 1'b1;
        vec_ff     <= SWI_CODE; // RL15
      end else if (hwTake) begin
        latched_ff <= 1'b1;
        vec_ff     <= winner; // RL10
      end
    end
  end
  assign intReq    = latched_ff;
  assign intVector = vec_ff;

  // Monitor mode follows a blank-vector reset until power-up.
  logic monitor_ff;
  always_ff @(posedge clk) begin
    if (!rstn || powerUpPulse) begin
      monitor_ff <= 1'b0;
    end else if (blankVec) begin
      monitor_ff <= 1'b1; // RL3
    end
  end
  assign monitorMode = monitor_ff;

  // Bus decode: one-wait-state ack, byte lane 0 carries the register.
  logic ack_ff;
  wire  acc     = wbCyc & wbStb & ~ack_ff;
  wire  selBrk  = wbAdr == OFS_BREAK;
  wire  selCse  = wbAdr == OFS_CAUSE;
  wire  brkWr   = acc & wbWe & wbSel[0] & selBrk;
  wire  cseRd   = acc & ~wbWe & selCse;
  wire  brkSet  = waitMode_ff & breakIrq & running;

  // Reset cause bits raised this cycle.
  logic [7:0] causeSet;
  assign causeSet[CS_POR]      = 1'b0;
  assign causeSet[CS_PIN]      = pinLow;
  assign causeSet[CS_WDOG]     = wdogTimeout;
  assign causeSet[CS_BADOP]    = badOpcode;
  assign causeSet[CS_BADFETCH] = badFetch; // RL23
  assign causeSet[CS_BLANK]    = blankVec;
  assign causeSet[CS_LOWSUP]   = lowSupDet; // RL5
  assign causeSet[0]           = 1'b0;

  logic [7:0] cause_ff, brk_ff;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ack_ff   <= 1'b0;
      wbDatR   <= '0;
      cause_ff <= CAUSE_POR_ONLY;
      brk_ff   <= BREAK_RST;
    end else begin
      ack_ff <= acc;
      wbDatR <= (acc & ~wbWe) ? {24'h0, selBrk ? brk_ff : selCse ? cause_ff : 8'h00} : 32'h0;
      if (powerUpPulse) begin
        cause_ff <= CAUSE_POR_ONLY; // RL22
      end else begin
        cause_ff <= (cseRd ? 8'h00 : cause_ff) | causeSet; // RL22
      end
      if (cpuReset) begin
        brk_ff <= BREAK_RST; // RL21
      end else if (brkSet) begin
        brk_ff[BRK_EXIT_BIT] <= 1'b1; // RL21
      end else if (brkWr && !wbDatW[BRK_EXIT_BIT]) begin
        brk_ff[BRK_EXIT_BIT] <= 1'b0;
      end
    end
  end
  assign wbAck = ack_ff;

  default clocking cbk @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_wait_in;
    running && waitExec && !intRst && !pinLow;
  endsequence
  sequence s_wake;
    waitMode_ff && anyPend && running && !intRst && !pinLow;
  endsequence

  property p_fetch_rst;
    badFetch |=> seq_ff == SEQ_DRIVE && cause_ff[CS_BADFETCH] ##1 rstPinOe;
  endproperty
  a_fetch_rst: assert property (p_fetch_rst) else $error("bad fetch gave no reset"); // RL1
  property p_data_rd;
    fetchValid && !fetchOpcode && !cause_ff[CS_BADFETCH] |=> !cause_ff[CS_BADFETCH] || $past(badFetch);
  endproperty
  a_data_rd: assert property (p_data_rd) else $error("data read set fetch flag"); // RL2
  property p_blank;
    blankVec |=> monitorMode && cpuReset;
  endproperty
  a_blank: assert property (p_blank) else $error("blank vector not handled"); // RL3
  property p_drive;
    seq_ff == SEQ_DRIVE |-> rstPinOe && !rstPinOut && cpuReset;
  endproperty
  a_drive: assert property (p_drive) else $error("reset pin not driven"); // RL6
  property p_pin_keeps;
    seq_ff == SEQ_PIN |=> cb.cnt == CNT_W'($past(cb.cnt) + $past(refTick));
  endproperty
  a_pin_keeps: assert property (p_pin_keeps) else $error("pin reset cleared prescaler"); // RL9
  property p_latch_hold;
    latched_ff && !intAck && !iMaskFell && running && !intRst |=> latched_ff && $stable(vec_ff);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched interrupt displaced"); // RL11
  property p_swi;
    swiExec && !latched_ff && running && !intRst && !pinLow |=> intReq && intVector == SWI_CODE;
  endproperty
  a_swi: assert property (p_swi) else $error("software trap not taken"); // RL15
  property p_wait;
    s_wait_in |=> !cpuClkEn && clrIMask && periphClkEn;
  endproperty
  a_wait: assert property (p_wait) else $error("wait entry wrong"); // RL17
  property p_wake;
    s_wake |=> !waitMode_ff && stackStart && intReq;
  endproperty
  a_wake: assert property (p_wake) else $error("wait wake stacking late"); // RL18
  property p_por;
    powerUpPulse |=> cause_ff == CAUSE_POR_ONLY;
  endproperty
  a_por: assert property (p_por) else $error("power-up cause wrong"); // RL22
endmodule : srx_system_ctrl

// file: testbench/srx_cpu_model.sv
// Behavioural CPU core that services interrupts latched by the controller.
// Assumes it shares the controller clock and sees its interrupt outputs directly.
`timescale 1ns/1ns
module srx_cpu_model
#(
  parameter int DLY = 2
)(
  input  logic clk,
  input  logic rstn,
  input  logic intReq,
  input  logic cpuClkEn,
  input  logic stall,
  output logic intAck
);
  logic [7:0] waitCnt_ff;

  // Stacks the latched interrupt DLY+1 cycles after it shows, unless held off.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      waitCnt_ff <= 8'h00;
      intAck     <= 1'b0;
    end else begin
      intAck <= 1'b0;
      if (intReq && cpuClkEn && !stall && !intAck) begin
        if (waitCnt_ff == 8'(DLY)) begin
          intAck     <= 1'b1;
          waitCnt_ff <= 8'h00;
        end else begin
          waitCnt_ff <= waitCnt_ff + 8'h01;
        end
      end else begin
        waitCnt_ff <= 8'h00;
      end
    end
  end
endmodule : srx_cpu_model

// file: testbench/tb_srx_system_ctrl.sv
// Self-checking bench for the system reset and exception controller.
// Assumes the reference clock runs at a quarter of clk and the pin has a pull-up.
`timescale 1ns/1ns
module tb_srx_system_ctrl
  import srx_pkg::*;
;
  typedef struct packed {logic [7:0] req; logic [7:0] en; logic msk; logic hit; logic [3:0] vec;} srx_row_t;
  localparam int CAUSE_OF[4] = '{CS_BADOP, CS_WDOG, CS_BADFETCH, CS_BLANK};
  logic        clk, rstn, wbCyc, wbStb, wbWe, wbAck, refClk, lowSupplyRaw, rstPinIn, rstPinOut, rstPinOe;
  logic        powerUpPulse, wdogTimeout, badOpcode, fetchValid, fetchOpcode, addrMapped, vectorFetch;
  logic        instrDone, rtiDone, swiExec, waitExec, stopExec, breakIrq, iMask, intAck, wdogDisable;
  logic        cpuReset, cpuClkEn, periphClkEn, clockgenEn, wdogClk, wdogRun, clrIMask, stackStart;
  logic        intReq, monitorMode, extRstN, stall;
  logic [1:0]  refCnt_ff;
  logic [3:0]  wbSel, intVector;
  logic [7:0]  wbAdr, vectorData, irqReq, irqEn;
  logic [12:0] pl;
  logic [31:0] wbDatW, wbDatR, rd;
  int          mismatches, nCompared, n;
  srx_row_t    rows[6];

  // Pulse lines of the CPU and the pin level seen with the pull-up.
  // Line 11 is power-up; line 12 is a legal opcode fetch with a programmed vector byte.
  assign {breakIrq, stopExec, waitExec, swiExec, rtiDone, instrDone} = pl[10:5];
  assign badOpcode    = pl[0];
  assign wdogTimeout  = pl[1];
  assign fetchValid   = pl[2] | pl[4] | pl[12];
  assign fetchOpcode  = pl[2] | pl[12];
  assign vectorFetch  = pl[3] | pl[12];
  assign addrMapped   = pl[12];
  assign vectorData   = pl[12] ? 8'h7f : BLANK_BYTE;
  assign powerUpPulse = pl[11];
  assign rstPinIn     = extRstN & ~rstPinOe;
  assign refClk       = refCnt_ff[1];

  srx_system_ctrl #(.IRQ_N(8), .BUS_DIV(1)) u_srx_system_ctrl (.*);
  srx_cpu_model #(.DLY(2)) u_srx_cpu_model (.clk(clk), .rstn(rstn), .intReq(intReq), .cpuClkEn(cpuClkEn),
                                            .stall(stall), .intAck(intAck));

  // Clock and reference divider.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) refCnt_ff <= rstn ? refCnt_ff + 2'h1 : 2'h0;

  // Compares one value and reports a difference.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  // One classic Wishbone cycle; read data lands in rd.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int waits = 0;
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= adr;
    wbDatW <= dat;
    wbSel  <= 4'hf;
    do begin
      @(posedge clk);
      waits++;
    end while (wbAck !== 1'b1);
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    chk("wbAck", 32'h2, waits);
    @(posedge clk);
  endtask : wb

  // Raises one pulse line for a single cycle, then lets its effect land.
  task automatic pulse(input int k);
    pl <= 13'h0001 << k;
    @(posedge clk);
    pl <= 13'h0000;
    @(posedge clk);
  endtask : pulse

  // Measures the pin drive and the following hold in clk cycles.
  task automatic rstseq(input int drv);
    int a, b;
    for (a = 0; rstPinOe === 1'b1 && a < 20000; a++) @(posedge clk);
    for (b = 0; cpuReset === 1'b1 && b < 2000; b++) @(posedge clk);
    chk("drive span", 32'h1, {31'h0, a > drv * 4 - 16 && a < drv * 4 + 16});
    chk("hold span", 32'h1, {31'h0, b > 240 && b < 276});
  endtask : rstseq

  // Prints the verdict and ends the run.
  task automatic conclude();
    if (mismatches == 0 && nCompared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  // Cuts a hung run short.
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    conclude();
  end

  // Main sequence: resets, then table of interrupt cases, then latch, low-power and pin reset cases.
  initial begin
    {rstn, wbCyc, wbStb, wbWe, iMask, wdogDisable, lowSupplyRaw, stall} = '0;
    {wbAdr, wbDatW, wbSel, pl, irqReq, irqEn} = '0;
    extRstN = 1'b1;
    rows = '{'{8'h05, 8'hff, 1'b0, 1'b1, 4'h0}, '{8'h80, 8'h80, 1'b0, 1'b1, 4'h7},
             '{8'h0c, 8'h08, 1'b0, 1'b1, 4'h3}, '{8'hff, 8'hff, 1'b1, 1'b0, 4'h0},
             '{8'h30, 8'h00, 1'b0, 1'b0, 4'h0}, '{8'h06, 8'h06, 1'b0, 1'b1, 4'h1}};
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    chk("reset state", 32'h3, {30'h0, rstPinOe, cpuReset});
    pulse(0);
    pulse(11);
    rstseq(4096);
    chk("clocks", 32'h3, {30'h0, cpuClkEn, periphClkEn});
    wb(1'b0, OFS_CAUSE, 32'h0);
    chk("cause", {24'h0, CAUSE_POR_ONLY}, rd);
    wb(1'b0, OFS_CAUSE, 32'h0);
    chk("cause", 32'h0, rd);
    pulse(4);
    pulse(12);
    repeat (4) @(posedge clk);
    chk("cpuReset", 32'h0, {31'h0, cpuReset});
    chk("monitorMode", 32'h0, {31'h0, monitorMode});
    wb(1'b0, OFS_CAUSE, 32'h0);
    chk("cause", 32'h0, rd);
    for (int k = 0; k < 4; k++) begin
      pulse(k);
      chk("pin drive", 32'h1, {31'h0, rstPinOe & ~rstPinOut & cpuReset});
      rstseq(32);
      wb(1'b0, OFS_CAUSE, 32'h0);
      chk("cause", 32'h1 << CAUSE_OF[k], rd);
    end
    chk("monitorMode", 32'h1, {31'h0, monitorMode});
    wdogDisable <= 1'b1;
    @(posedge clk);
    chk("wdogRun", 32'h0, {31'h0, wdogRun});
    wdogDisable <= 1'b0;
    @(posedge clk);
    chk("wdogRun", 32'h1, {31'h0, wdogRun});
    foreach (rows[i]) begin
      irqReq <= rows[i].req;
      irqEn  <= rows[i].en;
      iMask  <= rows[i].msk;
      pulse(5);
      chk("intReq", {31'h0, rows[i].hit}, {31'h0, intReq});
      if (rows[i].hit) chk("intVector", {28'h0, rows[i].vec}, {28'h0, intVector});
      irqReq <= 8'h00;
      repeat (8) @(posedge clk);
    end
    stall  <= 1'b1;
    irqReq <= 8'h08;
    irqEn  <= 8'hff;
    iMask  <= 1'b0;
    pulse(5);
    irqReq <= 8'h09;
    pulse(5);
    chk("intVector", 32'h3, {28'h0, intVector});
    iMask <= 1'b1;
    @(posedge clk);
    iMask <= 1'b0;
    repeat (3) @(posedge clk);
    chk("intReq", 32'h0, {31'h0, intReq});
    pulse(6);
    chk("intVector", 32'h10, {27'h0, intReq, intVector});
    stall  <= 1'b0;
    irqReq <= 8'h00;
    iMask  <= 1'b1;
    repeat (8) @(posedge clk);
    pulse(7);
    chk("intVector", 32'h18, {27'h0, intReq, intVector});
    iMask <= 1'b0;
    repeat (8) @(posedge clk);
    pulse(8);
    chk("wait entry", 32'h5, {29'h0, clrIMask, cpuClkEn, periphClkEn});
    irqReq <= 8'h02;
    repeat (2) @(posedge clk);
    chk("wake", 32'h71, {25'h0, stackStart, intReq, cpuClkEn, intVector});
    irqReq <= 8'h00;
    repeat (8) @(posedge clk);
    pulse(8);
    pulse(10);
    wb(1'b0, OFS_BREAK, 32'h0);
    chk("break flag", 32'h1 << BRK_EXIT_BIT, rd);
    wb(1'b1, OFS_BREAK, 32'h0);
    wb(1'b0, OFS_BREAK, 32'h0);
    chk("break flag", 32'h0, rd);
    extRstN <= 1'b0;
    repeat (8) @(posedge clk);
    chk("pin reset", 32'h1, {31'h0, cpuReset});
    extRstN <= 1'b1;
    rstseq(0);
    wb(1'b0, OFS_CAUSE, 32'h0);
    chk("cause", 32'h1 << CS_PIN, rd);
    pulse(9);
    chk("clockgenEn", 32'h0, {31'h0, clockgenEn});
    irqReq <= 8'h01;
    for (n = 0; stackStart !== 1'b1 && n < 20000; n++) @(posedge clk);
    chk("stop recovery", 32'h1, {31'h0, n > 16368 && n < 16400});
    irqReq <= 8'h00;
    for (n = 0; wdogClk !== 1'b1 && n < 20000; n++) @(posedge clk);
    chk("wdogClk", 32'h1, {31'h0, n > 16368 && n < 16400});
    lowSupplyRaw <= 1'b1;
    repeat (24) @(posedge clk);
    chk("early reset", 32'h0, {31'h0, cpuReset});
    for (n = 0; cpuReset !== 1'b1 && n < 100; n++) @(posedge clk);
    chk("filter span", 32'h1, {31'h0, n > 11 && n < 18});
    lowSupplyRaw <= 1'b0;
    rstseq(4096);
    wb(1'b0, OFS_CAUSE, 32'h0);
    chk("cause", 32'h1 << CS_LOWSUP, rd);
    conclude();
  end
endmodule : tb_srx_system_ctrl
